//--- bench/umc_mode_config_tb_top.sv
// Purpose: self-checking bench for the serial mode configuration block
// Assumes: baudTick held high, so one bit is 16 or 4 cycles
// Notes:   reset values and unmapped accesses first, then register rows, pins, frames, rate measure, wake, loopback, reset
`timescale 1ns/1ps
`default_nettype none
module umc_mode_config_tb_top;
  typedef struct packed {
    logic [31:0] w;
    logic [31:0] r;
    logic [4:0]  u;
  } umcTbRow_t;
  // mode written, mode read back, pin usage {tx,rx,cts,rts,bclk}
  localparam umcTbRow_t ROWS [5] = '{
    '{32'h0000_0000, 32'h0000_0000, 5'h18},
    '{32'h0000_0500, 32'h0000_0100, 5'h1A},
    '{32'h0000_0200, 32'h0000_0200, 5'h1E},
    '{32'h0000_0300, 32'h0000_0300, 5'h19},
    '{32'h0000_04DF, 32'h0000_00DF, 5'h18}};

  logic                clk_sys = 1'b0;
  logic                rst_n;
  umc_pkg::umcBusReq_t busReq;
  logic [31:0]         busRdData;
  logic                baudTick;
  logic                sleepMode;
  logic                rxPin;
  logic                ctsPinN;
  logic                txPin;
  logic                rtsPinN;
  logic                baudClkPin;
  logic                wakeUp;
  umc_pkg::umcPinUse_t pinUse;
  logic [31:0]         d;
  logic [8:0]          bits;
  logic                bPrev = 1'b0;
  int                  nFail = 0;
  int                  checksDone = 0;
  int                  cyc = 0;
  int                  nWake = 0;
  int                  nTxLow = 0;
  int                  nBclk = 0;
  int                  w, t0, n, len;

  always #25 clk_sys = ~clk_sys;

  umc_mode_config dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .busReq(busReq), .busRdData(busRdData),
    .baudTick(baudTick), .sleepMode(sleepMode), .rxPin(rxPin), .ctsPinN(ctsPinN),
    .txPin(txPin), .rtsPinN(rtsPinN), .baudClkPin(baudClkPin), .wakeUp(wakeUp),
    .pinUse(pinUse));

  umc_serial_peer peer (.clk_sys(clk_sys), .txLine(txPin), .rxLine(rxPin));

  // pulse and toggle counters, sampled away from the launching edge
  always @(negedge clk_sys)
  begin
    bPrev <= baudClkPin;
    if (wakeUp === 1'b1) nWake <= nWake + 1;
    if (txPin === 1'b0) nTxLow <= nTxLow + 1;
    if (baudClkPin !== bPrev) nBclk <= nBclk + 1;
  end

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      nFail++;
      stopTest();
    end
  end

  task automatic stopTest();
    $display("checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    checksDone++;
    if (g !== e)
    begin
      nFail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, g, e);
    end
  endtask

  task automatic chkIn(input logic [31:0] g, input int lo, input int hi, input string msg);
    checksDone++;
    if ((g >= 32'(lo) && g <= 32'(hi)) !== 1'b1)
    begin
      nFail++;
      $display("[FAIL] %0t %s: got %0d want %0d..%0d", $time, msg, g, lo, hi);
    end
  endtask

  // one-cycle write strobe, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
  endtask

  // one-cycle read strobe; data taken at the edge that closes the answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
    v = busRdData;
  endtask

  // the nine slots after the start bit for each framing code
  function automatic logic [8:0] expSlots(input logic [8:0] v, input logic [1:0] f);
    case (f)
      umc_pkg::FMT_8N: return {1'b1, v[7:0]};
      umc_pkg::FMT_8E: return {^v[7:0], v[7:0]};
      umc_pkg::FMT_8O: return {~^v[7:0], v[7:0]};
      default:         return v;
    endcase
  endfunction

  initial
  begin
    busReq = '0;
    baudTick = 1'b0;
    sleepMode = 1'b0;
    ctsPinN = 1'b1;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'({txPin, rtsPinN, baudClkPin, wakeUp}), 32'h0000_000C, "reset pins");
    chk(32'(pinUse), 32'h0000_0018, "reset pin usage");
    chk(busRdData, 32'h0000_0000, "reset read data");
    rd(umc_pkg::OFS_MODE, d);
    chk(d, umc_pkg::MODE_RESET, "mode reset");
    baudTick <= 1'b1;
    wr(8'h10, 32'hFFFF_FFFF);
    rd(umc_pkg::OFS_MODE, d);
    chk(d, 32'h0000_0000, "unmapped write");
    rd(8'h10, d);
    chk(d, 32'h0000_0000, "unmapped read");
    // register rows
    foreach (ROWS[i])
    begin
      wr(umc_pkg::OFS_MODE, ROWS[i].w);
      rd(umc_pkg::OFS_MODE, d);
      chk(d, ROWS[i].r, "mode readback");
      chk(32'(pinUse), 32'(ROWS[i].u), "pin usage");
    end
    // baud clock pin, then pin code held while on
    wr(umc_pkg::OFS_MODE, 32'h0000_0000);
    wr(umc_pkg::OFS_MODE, 32'h0000_0300);
    wr(umc_pkg::OFS_MODE, 32'h0000_8300);
    repeat (2) @(posedge clk_sys);
    n = nBclk;
    repeat (8) @(posedge clk_sys);
    chk(32'(nBclk - n), 32'h0000_0008, "baud clock toggles");
    wr(umc_pkg::OFS_MODE, 32'h0000_8000);
    rd(umc_pkg::OFS_MODE, d);
    chk(d, 32'h0000_8300, "pin code kept while on");
    // flow control and simplex request pin, clear-to-send gating
    wr(umc_pkg::OFS_MODE, 32'h0000_0000);
    wr(umc_pkg::OFS_MODE, 32'h0000_0200);
    wr(umc_pkg::OFS_MODE, 32'h0000_8200);
    repeat (3) @(posedge clk_sys);
    chk(32'(rtsPinN), 32'h0000_0000, "flow rts");
    wr(umc_pkg::OFS_MODE, 32'h0000_0000);
    wr(umc_pkg::OFS_MODE, 32'h0000_0A00);
    wr(umc_pkg::OFS_MODE, 32'h0000_8A00);
    repeat (3) @(posedge clk_sys);
    chk(32'(rtsPinN), 32'h0000_0001, "simplex rts idle");
    wr(umc_pkg::OFS_TXDATA, 32'h0000_00FF);
    repeat (60) @(posedge clk_sys);
    chk(32'(txPin), 32'h0000_0001, "held by cts");
    ctsPinN <= 1'b0;
    peer.getFrame(bits, w, t0);
    chk(32'(bits[7:0]), 32'h0000_00FF, "cts frame");
    chk(32'(rtsPinN), 32'h0000_0000, "simplex rts sending");
    // framing codes and stop counts at 16x, last pass at 4x
    for (int i = 0; i < 5; i++)
    begin
      len = ((i == 0 || i == 4) ? 10 : 11) + (i & 1);
      wr(umc_pkg::OFS_MODE, 32'h0000_0000);
      wr(umc_pkg::OFS_MODE, (i == 4) ? 32'h0000_8008 : 32'h0000_8000 | 32'(i << 1) | 32'(i & 1));
      fork
        peer.getFrame(bits, w, t0);
        wr(umc_pkg::OFS_TXDATA, 32'h0000_01A5);
      join
      chk(32'(bits), 32'(expSlots(9'h1A5, 2'(i))), "frame slots");
      chk(32'(w), (i == 4) ? 32'h0000_0004 : 32'h0000_0010, "bit width");
      n = 0;
      do
      begin
        rd(umc_pkg::OFS_STATUS, d);
        n++;
      end while (d[1] !== 1'b0 && n < 400);
      chkIn(32'(peer.nCyc - t0), len * w - 3, len * w + 3, "frame length");
    end
    // rate measure on a sync character in both polarities
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(umc_pkg::OFS_MODE, 32'h0000_0000);
      peer.setIdle(inv == 0);
      wr(umc_pkg::OFS_MODE, 32'h0000_8000 | 32'(inv << 4));
      repeat (4) @(posedge clk_sys);
      rd(umc_pkg::OFS_STATUS, d);
      chk(32'(d[3]), 32'h0000_0001, "idle level");
      wr(umc_pkg::OFS_MODE, 32'h0000_8020 | 32'(inv << 4));
      rd(umc_pkg::OFS_MODE, d);
      chk(32'(d[5]), 32'h0000_0001, "measure armed");
      peer.sendByte(8'h55, 40);
      repeat (4) @(posedge clk_sys);
      rd(umc_pkg::OFS_RATE, d);
      chkIn(d, 39, 40, "measured rate");
      rd(umc_pkg::OFS_MODE, d);
      chk(32'(d[5]), 32'h0000_0000, "measure self-clear");
    end
    // wake on start edge during sleep, enabled and disabled
    wr(umc_pkg::OFS_MODE, 32'h0000_0000);
    peer.setIdle(1'b1);
    sleepMode <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(umc_pkg::OFS_MODE, 32'(k << 7));
      n = nWake;
      peer.sendByte(8'hFF, 8);
      chk(32'(nWake - n), 32'(k), "wake pulses");
    end
    sleepMode <= 1'b0;
    // loopback: pin stays idle, receiver sees the frame
    wr(umc_pkg::OFS_MODE, 32'h0000_8040);
    len = nTxLow;
    n = 0;
    wr(umc_pkg::OFS_TXDATA, 32'h0000_00FE);
    repeat (60)
    begin
      rd(umc_pkg::OFS_STATUS, d);
      if (d[3] === 1'b0) n = 1;
    end
    chk(32'(n), 32'h0000_0001, "loop frame received");
    chk(32'(nTxLow - len), 32'h0000_0000, "pin quiet in loop");
    // reset in mid-frame: pins and mode word return to rest
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'({txPin, rtsPinN, baudClkPin, wakeUp}), 32'h0000_000C, "pins after reset");
    rd(umc_pkg::OFS_MODE, d);
    chk(d, umc_pkg::MODE_RESET, "mode after reset");
    stopTest();
  end
endmodule
`default_nettype wire

//--- bench/umc_serial_peer.sv
// Purpose: remote serial device that sends characters and catches frames
// Assumes: one bit lasts a whole number of clk_sys cycles
// Notes:   rx changes after rising edges; tx is sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module umc_serial_peer (
  input  wire logic clk_sys,
  input  wire logic txLine,
  output var logic  rxLine = 1'b1
);
  logic idleLvl = 1'b1;
  int   nCyc    = 0;

  // free cycle count for frame timing
  always @(negedge clk_sys) nCyc <= nCyc + 1;

  // park the line at the level the receiver should call idle
  task automatic setIdle(input logic lvl);
    idleLvl = lvl;
    rxLine <= lvl;
    @(posedge clk_sys);
  endtask

  // start, eight data bits lsb first, one stop, in the current polarity
  task automatic sendByte(input logic [7:0] b, input int cpb);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxLine <= f[i] ^ ~idleLvl;
      repeat (cpb) @(posedge clk_sys);
    end
  endtask

  // wait for a start bit, measure it, sample the nine slots after it;
  // returns at a rising edge right after the last sample
  task automatic getFrame(output logic [8:0] bits, output int w, output int tf);
    int n;
    n = 0;
    w = 0;
    bits = '0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end while (txLine !== 1'b0 && n < 4000);
    tf = nCyc;
    do
    begin
      w++;
      @(negedge clk_sys);
    end while (txLine === 1'b0 && w < 400);
    for (int i = 0; i < 9; i++)
    begin
      repeat ((i == 0) ? w / 2 : w) @(negedge clk_sys);
      bits[i] = txLine;
    end
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- common/umc_pkg.sv
// Purpose: shared constants and types for the serial mode configuration block
// Assumes: 32-bit register words, byte addresses on an 8-bit address port
// Notes:   all state of the block except the assertion helpers tickCnt and expLen travels in umcState_t
package umc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RATE   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // mode word field positions
  localparam int BIT_ON     = 15;
  localparam int BIT_RTSMOD = 11;
  localparam int BIT_UNIMP  = 10;
  localparam int BIT_PINHI  = 9;
  localparam int BIT_PINLO  = 8;
  localparam int BIT_WAKE   = 7;
  localparam int BIT_LOOP   = 6;
  localparam int BIT_AUTO_RATE_MEASURE  = 5;
  localparam int BIT_RECEIVE_IDLE_POLARITY  = 4;
  localparam int BIT_FAST   = 3;
  localparam int BIT_FMTHI  = 2;
  localparam int BIT_FMTLO  = 1;
  localparam int BIT_STOP2  = 0;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // pin enable combinations
  localparam logic [1:0] PIN_TXRX  = 2'h0;
  localparam logic [1:0] PIN_RTS   = 2'h1;
  localparam logic [1:0] PIN_FLOW  = 2'h2;
  localparam logic [1:0] PIN_BCLK  = 2'h3;

  // framing codes and frame lengths in bit times
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;
  localparam logic [3:0] LEN_8N = 4'hA;
  localparam logic [3:0] LEN_8P = 4'hB;
  localparam logic [3:0] LEN_9N = 4'hB;

  // oversample counter tops: 16x and 4x
  localparam logic [3:0] OVS_STD  = 4'hF;
  localparam logic [3:0] OVS_FAST = 4'h3;

  // sync character 0x55: five falling edges span eight bit times
  localparam logic [2:0] SYNC_LAST_FALL = 3'h3;
  localparam int         SYNC_SHIFT     = 3;
  localparam int         AB_W           = 16;

  typedef enum logic {TX_IDLE, TX_SHIFT} umcTxState_t;
  typedef enum logic [1:0] {AB_IDLE, AB_WAIT, AB_COUNT} umcAbState_t;

  typedef struct packed {
    logic       on;
    logic       rtsSimplex;
    logic [1:0] pinEn;
    logic       wake;
    logic       loop;
    logic       auto_rate_measure;
    logic       receive_idle_polarity;
    logic       fast;
    logic [1:0] frame;
    logic       stop2;
  } umcMode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } umcBusReq_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic cts;
    logic rts;
    logic bclk;
  } umcPinUse_t;

  typedef struct packed {
    umcMode_t        mode;
    logic            rxS1;
    logic            rxS2;
    logic            ctsS1;
    logic            ctsS2;
    logic            rxPrev;
    umcTxState_t     txState;
    logic [11:0]     txShift;
    logic [3:0]      txBits;
    logic [8:0]      txHold;
    logic            txPend;
    logic [3:0]      ovCnt;
    logic            txLine;
    logic            txOut;
    logic            rtsN;
    logic            bclk;
    logic            wakeUp;
    umcPinUse_t      pinUse;
    umcAbState_t     abState;
    logic [2:0]      abFalls;
    logic [AB_W-1:0] abCnt;
    logic [AB_W-1:0] rate;
    logic [31:0]     rdData;
  } umcState_t;

endpackage

//--- design/umc_mode_config.sv
// Purpose: serial transceiver mode register with the transmit framer,
//          receive line conditioning, wake detect and sync-rate measurement
// Assumes: baudTick is a one-cycle enable from a rate generator on clk_sys
// Notes:   pin usage flags are advisory; real pin routing lives elsewhere
`timescale 1ns/1ps
`default_nettype none

module umc_mode_config (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire umc_pkg::umcBusReq_t     busReq,
  output logic [31:0]                  busRdData,
  input  wire logic                    baudTick,
  input  wire logic                    sleepMode,
  input  wire logic                    rxPin,
  input  wire logic                    ctsPinN,
  output logic                         txPin,
  output logic                         rtsPinN,
  output logic                         baudClkPin,
  output logic                         wakeUp,
  output umc_pkg::umcPinUse_t          pinUse
);

  umc_pkg::umcState_t st_r;
  umc_pkg::umcState_t st_nxt;
  umc_pkg::umcMode_t  wrMode;
  logic [3:0]         ovTop;
  logic               bitTick;
  logic               rxSrc;
  logic               rxLevel;
  logic               rxFall;
  logic               txBusy;
  logic               ctsOk;

  // mode word to fields
  function automatic umc_pkg::umcMode_t modeFields(input logic [31:0] w);
    umc_pkg::umcMode_t m;
    m.on         = w[umc_pkg::BIT_ON];
    m.rtsSimplex = w[umc_pkg::BIT_RTSMOD];
    m.pinEn      = w[umc_pkg::BIT_PINHI:umc_pkg::BIT_PINLO];
    m.wake       = w[umc_pkg::BIT_WAKE];
    m.loop       = w[umc_pkg::BIT_LOOP];
    m.auto_rate_measure      = w[umc_pkg::BIT_AUTO_RATE_MEASURE];
    m.receive_idle_polarity      = w[umc_pkg::BIT_RECEIVE_IDLE_POLARITY];
    m.fast       = w[umc_pkg::BIT_FAST];
    m.frame      = w[umc_pkg::BIT_FMTHI:umc_pkg::BIT_FMTLO];
    m.stop2      = w[umc_pkg::BIT_STOP2];
    return m;
  endfunction

  // fields to mode word; the unimplemented bit stays zero
  function automatic logic [31:0] modeWord(input umc_pkg::umcMode_t m);
    logic [31:0] w;
    w = umc_pkg::MODE_RESET;
    w[umc_pkg::BIT_ON]                         = m.on;
    w[umc_pkg::BIT_RTSMOD]                     = m.rtsSimplex;
    w[umc_pkg::BIT_PINHI:umc_pkg::BIT_PINLO]   = m.pinEn;
    w[umc_pkg::BIT_WAKE]                       = m.wake;
    w[umc_pkg::BIT_LOOP]                       = m.loop;
    w[umc_pkg::BIT_AUTO_RATE_MEASURE]                      = m.auto_rate_measure;
    w[umc_pkg::BIT_RECEIVE_IDLE_POLARITY]                      = m.receive_idle_polarity;
    w[umc_pkg::BIT_FAST]                       = m.fast;
    w[umc_pkg::BIT_FMTHI:umc_pkg::BIT_FMTLO]   = m.frame;
    w[umc_pkg::BIT_STOP2]                      = m.stop2;
    return w;
  endfunction

  // frame bits lsb first: start, data, parity, stops, idle fill
  function automatic logic [11:0] buildFrame(input logic [8:0] d, input logic [1:0] fmt);
    logic [11:0] f;
    case (fmt)
      umc_pkg::FMT_9N: f = {2'h3, d, 1'b0};
      umc_pkg::FMT_8O: f = {2'h3, ~^d[7:0], d[7:0], 1'b0};
      umc_pkg::FMT_8E: f = {2'h3, ^d[7:0], d[7:0], 1'b0};
      default:         f = {3'h7, d[7:0], 1'b0};
    endcase
    return f;
  endfunction

  // frame length in bit times including stop bits
  function automatic logic [3:0] frameLen(input umc_pkg::umcMode_t m);
    logic [3:0] n;
    case (m.frame)
      umc_pkg::FMT_9N: n = umc_pkg::LEN_9N;
      umc_pkg::FMT_8N: n = umc_pkg::LEN_8N;
      default:         n = umc_pkg::LEN_8P;
    endcase
    return n + {3'h0, m.stop2};
  endfunction

  // oversample tick, receive line conditioning
  assign ovTop   = st_r.mode.fast ? umc_pkg::OVS_FAST : umc_pkg::OVS_STD;
  assign bitTick = st_r.mode.on && baudTick && (st_r.ovCnt == ovTop);
  assign rxSrc   = st_r.mode.loop ? st_r.txLine : st_r.rxS2;
  assign rxLevel = rxSrc ^ st_r.mode.receive_idle_polarity;
  assign rxFall  = st_r.rxPrev && !rxLevel;
  assign txBusy  = (st_r.txState == umc_pkg::TX_SHIFT);
  assign ctsOk   = (st_r.mode.pinEn != umc_pkg::PIN_FLOW) || !st_r.ctsS2;

  // software's mode write, pin enable held while on
  always_comb
  begin
    wrMode = modeFields(busReq.wdata);
    if (st_r.mode.on)
    begin
      wrMode.pinEn = st_r.mode.pinEn;
    end
  end

  // next state of the whole block
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rxS1   = rxPin;
    st_nxt.rxS2   = st_r.rxS1;
    st_nxt.ctsS1  = ctsPinN;
    st_nxt.ctsS2  = st_r.ctsS1;
    st_nxt.rxPrev = rxLevel;
    st_nxt.wakeUp = sleepMode && st_r.mode.wake && rxFall;
    // pin usage flags for the external routing logic
    st_nxt.pinUse.tx   = 1'b1;
    st_nxt.pinUse.rx   = 1'b1;
    st_nxt.pinUse.cts  = (st_r.mode.pinEn == umc_pkg::PIN_FLOW);
    st_nxt.pinUse.rts  = (st_r.mode.pinEn == umc_pkg::PIN_FLOW) ||
                         (st_r.mode.pinEn == umc_pkg::PIN_RTS);
    st_nxt.pinUse.bclk = (st_r.mode.pinEn == umc_pkg::PIN_BCLK);
    // oversample divider and baud clock output
    if (!st_r.mode.on)
    begin
      st_nxt.ovCnt = 4'h0;
    end
    else if (baudTick)
    begin
      st_nxt.ovCnt = bitTick ? 4'h0 : st_r.ovCnt + 4'h1;
    end
    if (!st_r.pinUse.bclk || !st_r.mode.on)
    begin
      st_nxt.bclk = 1'b0;
    end
    else if (baudTick)
    begin
      st_nxt.bclk = !st_r.bclk;
    end
    // transmit framer
    case (st_r.txState)
      umc_pkg::TX_IDLE:
      begin
        if (st_r.txPend && ctsOk)
        begin
          st_nxt.txShift = buildFrame(st_r.txHold, st_r.mode.frame);
          st_nxt.txBits  = frameLen(st_r.mode);
          st_nxt.txPend  = 1'b0;
          st_nxt.txState = umc_pkg::TX_SHIFT;
        end
      end
      umc_pkg::TX_SHIFT:
      begin
        if (bitTick)
        begin
          if (st_r.txBits == 4'h0)
          begin
            st_nxt.txState = umc_pkg::TX_IDLE;
          end
          else
          begin
            st_nxt.txLine  = st_r.txShift[0];
            st_nxt.txShift = {1'b1, st_r.txShift[11:1]};
            st_nxt.txBits  = st_r.txBits - 4'h1;
          end
        end
      end
      default:
      begin
        st_nxt.txState = umc_pkg::TX_IDLE;
      end
    endcase
    if (!st_r.mode.on)
    begin
      st_nxt.txState = umc_pkg::TX_IDLE;
      st_nxt.txLine  = 1'b1;
      st_nxt.txPend  = 1'b0;
    end
    // pin stays idle while looped back internally
    st_nxt.txOut = st_r.mode.loop ? 1'b1 : st_r.txLine;
    // request-to-send: simplex asserts while sending, flow control while on
    if (!st_r.pinUse.rts)
    begin
      st_nxt.rtsN = 1'b1;
    end
    else if (st_r.mode.rtsSimplex)
    begin
      st_nxt.rtsN = !txBusy;
    end
    else
    begin
      st_nxt.rtsN = !st_r.mode.on;
    end
    // sync character rate measurement
    case (st_r.abState)
      umc_pkg::AB_IDLE:
      begin
        if (st_r.mode.on && st_r.mode.auto_rate_measure)
        begin
          st_nxt.abState = umc_pkg::AB_WAIT;
        end
      end
      umc_pkg::AB_WAIT:
      begin
        if (!st_r.mode.auto_rate_measure || !st_r.mode.on)
        begin
          st_nxt.abState = umc_pkg::AB_IDLE;
        end
        else if (rxFall)
        begin
          st_nxt.abCnt   = '0;
          st_nxt.abFalls = 3'h0;
          st_nxt.abState = umc_pkg::AB_COUNT;
        end
      end
      umc_pkg::AB_COUNT:
      begin
        st_nxt.abCnt = st_r.abCnt + 1'b1;
        if (!st_r.mode.auto_rate_measure || !st_r.mode.on)
        begin
          st_nxt.abState = umc_pkg::AB_IDLE;
        end
        else if (rxFall)
        begin
          if (st_r.abFalls == umc_pkg::SYNC_LAST_FALL)
          begin
            st_nxt.rate       = (st_r.abCnt + 1'b1) >> umc_pkg::SYNC_SHIFT;
            st_nxt.mode.auto_rate_measure = 1'b0;
            st_nxt.abState    = umc_pkg::AB_IDLE;
          end
          else
          begin
            st_nxt.abFalls = st_r.abFalls + 3'h1;
          end
        end
      end
      default:
      begin
        st_nxt.abState = umc_pkg::AB_IDLE;
      end
    endcase
    // register writes; a software write lands after the hardware clear
    if (busReq.wr)
    begin
      case (busReq.addr)
        umc_pkg::OFS_MODE:
        begin
          st_nxt.mode = wrMode;
        end
        umc_pkg::OFS_TXDATA:
        begin
          if (!st_r.txPend && st_r.mode.on)
          begin
            st_nxt.txHold = busReq.wdata[8:0];
            st_nxt.txPend = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end
    // register reads, answered in the next cycle only
    st_nxt.rdData = '0;
    if (busReq.rd)
    begin
      case (busReq.addr)
        umc_pkg::OFS_MODE:   st_nxt.rdData = modeWord(st_r.mode);
        umc_pkg::OFS_TXDATA: st_nxt.rdData[8:0] = st_r.txHold;
        umc_pkg::OFS_RATE:   st_nxt.rdData[umc_pkg::AB_W-1:0] = st_r.rate;
        umc_pkg::OFS_STATUS: st_nxt.rdData[3:0] = {rxLevel, st_r.abState != umc_pkg::AB_IDLE,
                                                   txBusy, st_r.txPend};
        default:             st_nxt.rdData = '0;
      endcase
    end
  end

  // state register; lines rest at their idle level
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r        <= '0;
      st_r.rxS1   <= 1'b1;
      st_r.rxS2   <= 1'b1;
      st_r.ctsS1  <= 1'b1;
      st_r.ctsS2  <= 1'b1;
      st_r.rxPrev <= 1'b1;
      st_r.txLine <= 1'b1;
      st_r.txOut  <= 1'b1;
      st_r.rtsN   <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign busRdData  = st_r.rdData;
  assign txPin      = st_r.txOut;
  assign rtsPinN    = st_r.rtsN;
  assign baudClkPin = st_r.bclk;
  assign wakeUp     = st_r.wakeUp;
  assign pinUse     = st_r.pinUse;

  // helper: bit ticks spent on the current frame and its expected length
  logic [3:0] tickCnt;
  logic [3:0] expLen;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt <= 4'h0;
      expLen  <= 4'h0;
    end
    else if (!txBusy && st_nxt.txState == umc_pkg::TX_SHIFT)
    begin
      tickCnt <= 4'h0;
      expLen  <= umc_pkg::LEN_8N + {3'h0, st_r.mode.frame != umc_pkg::FMT_8N} + {3'h0, st_r.mode.stop2};
    end
    else if (bitTick && txBusy)
    begin
      tickCnt <= tickCnt + 4'h1;
    end
  end

  a_frame_length:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      txBusy && bitTick && st_r.txBits == 4'h0 |-> tickCnt == expLen)
    else $error("frame length does not match framing and stop setting");

  a_mode_bit_ten:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      busReq.rd && busReq.addr == umc_pkg::OFS_MODE |=> !busRdData[umc_pkg::BIT_UNIMP])
    else $error("unimplemented mode bit read back as one");

  a_pin_lock_on:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.mode.on |=> st_r.mode.pinEn == $past(st_r.mode.pinEn))
    else $error("pin enable changed while module on");

  a_auto_rate_measure_self_clear:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.abState == umc_pkg::AB_COUNT && st_r.mode.auto_rate_measure && st_r.mode.on && rxFall &&
      st_r.abFalls == umc_pkg::SYNC_LAST_FALL && !busReq.wr
      |=> !st_r.mode.auto_rate_measure && st_r.abState == umc_pkg::AB_IDLE)
    else $error("auto-baud bit not cleared at end of sync");

  a_wake_cause:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      wakeUp |-> $past(sleepMode && st_r.mode.wake && rxFall))
    else $error("wake-up without enabled start edge in sleep");

  a_loop_route:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(st_r.mode.loop) && st_r.mode.loop
      |-> st_r.rxPrev == ($past(st_r.txLine) ^ $past(st_r.mode.receive_idle_polarity)) && txPin)
    else $error("loopback does not route transmitter to receiver");

  a_rx_polarity:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !$past(st_r.mode.loop) |-> st_r.rxPrev == ($past(st_r.rxS2) ^ $past(st_r.mode.receive_idle_polarity)))
    else $error("receive level ignores polarity select");

  a_oversample_top:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.mode.on && baudTick && !st_r.mode.fast
      |=> st_r.ovCnt == (($past(st_r.ovCnt) == umc_pkg::OVS_STD) ? 4'h0 : $past(st_r.ovCnt) + 4'h1))
    else $error("standard mode does not step through sixteen phases");

  a_fast_top:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.mode.on && baudTick && st_r.mode.fast && st_r.ovCnt == umc_pkg::OVS_FAST
      |=> st_r.ovCnt == 4'h0)
    else $error("fast mode did not wrap after four phases");

  a_cts_holds_off:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !txBusy && st_r.mode.pinEn == umc_pkg::PIN_FLOW && st_r.ctsS2 |=> !txBusy)
    else $error("frame started while clear-to-send deasserted");

  a_rts_simplex:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.pinUse.rts && st_r.mode.rtsSimplex |=> rtsPinN == !$past(txBusy))
    else $error("simplex request-to-send not following transmitter");

  a_pin_use_map:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(st_r.mode.pinEn) == umc_pkg::PIN_TXRX |-> !pinUse.cts && !pinUse.rts && !pinUse.bclk)
    else $error("handshake pins claimed with tx/rx-only code");

endmodule
`default_nettype wire
